// >>> shared/apr_map.svh
// Named constants for the accelerometer pulse rebalance digitizer.
`ifndef APR_MAP_SVH
`define APR_MAP_SVH

// Default counter capacity in counts; the reset point is half of it.
`define APR_CNT_CAP 16
// Sample strobe width as supplied by the computer, in nanoseconds.
`define APR_STROBE_NS 3000
// System clock rate in megahertz.
`define APR_CLK_MHZ 50
// Nominal strobe width in clock cycles, rounded up.
`define APR_STROBE_CYC ((`APR_STROBE_NS * `APR_CLK_MHZ + 999) / 1000)
// Direction held by the latch and torque flip-flop after reset.
`define APR_DIR_RST apr_pkg::APR_NEG
// Depth of the comparator input synchroniser.
`define APR_SYNC_DEPTH 3

`endif

// >>> shared/apr_pkg.sv
// Types shared by the accelerometer pulse rebalance digitizer.
`default_nettype none
package apr_pkg;

   // Sign held by the interrogator latch and the torque-direction flip-flop.
   typedef enum logic {
      APR_NEG,
      APR_POS
   } apr_dir_e;

   // A positive and a negative line that travel together.
   typedef struct packed {
      logic pos;
      logic neg;
   } apr_pair_s;

endpackage : apr_pkg
`default_nettype wire

// >>> rtl/apr_digitizer.sv
// Interrogator, torque-direction flip-flop and forward-backward counter of one accelerometer loop.
//
// Overview of operation
// - Zero phase gives positive, pi negative set.
// - Latch set/reset by comparator ANDed strobe.
// - Positive and negative set pulses never together.
// - Data pulse marks each strobe leading edge.
// - Direction holds on same-sign set pulses.
// - Opposite-sign set pulse flips direction.
// - Direction alone selects the driven coil.
// - Data pulse gated by direction gives velocity.
// - Counter counts up positive, down negative.
// - Balanced three-three pattern gives no increments.
// - Counter overflow emits velocity increment pulses.
// - Strobe timing synchronous to the system clock.
`timescale 1ns/10ps
`default_nettype none
`include "apr_map.svh"

module apr_digitizer #(
   parameter int unsigned CNT_CAP = `APR_CNT_CAP
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic zero_phase_i,
   input wire logic pi_phase_i,
   input wire logic sample_strobe_i,
   output apr_pkg::apr_pair_s torque_set_o,
   output logic data_pulse_o,
   output apr_pkg::apr_pair_s coil_o,
   output apr_pkg::apr_pair_s velocity_o,
   output apr_pkg::apr_pair_s increment_o
);
   import apr_pkg::*;

   localparam int unsigned CNT_W = (CNT_CAP > 2) ? $clog2(CNT_CAP) : 1;
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(CNT_CAP - 1);
   localparam logic [CNT_W-1:0] CNT_MID = CNT_W'(CNT_CAP / 2);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_MIN = CNT_W'(0);
   localparam int STROBE_CYC = `APR_STROBE_CYC;
   localparam int unsigned RUN_W = $clog2(STROBE_CYC + 1);
   localparam logic [RUN_W-1:0] RUN_MAX = RUN_W'(STROBE_CYC);
   localparam logic [RUN_W-1:0] RUN_ONE = RUN_W'(1);

   // Turns a direction and a gate into the pair of positive and negative lines.
   function automatic apr_pair_s pair_of(input apr_dir_e dir, input logic gate);
      apr_pair_s p;
      p.pos = gate && (dir == APR_POS);
      p.neg = gate && (dir == APR_NEG);
      return p;
   endfunction : pair_of

   logic [1:0] cmp_raw;
   logic [1:0] cmp_lvl_ff;
   logic strobe_d_ff;
   logic strobe_rise;
   apr_dir_e latch_ff;
   apr_dir_e nxt_latch;
   apr_pair_s set_ff;
   logic data_ff;
   apr_dir_e dir_ff;
   apr_dir_e nxt_dir;
   apr_pair_s vel_ff;
   logic [CNT_W-1:0] cnt_ff;
   apr_pair_s inc_ff;
   logic [RUN_W-1:0] strobe_run_ff;

   assign cmp_raw = {pi_phase_i, zero_phase_i};

   // The comparators are analog levels with no timing relation to the clock,
   // so each passes three stages and a new level counts only once the last
   // two stages agree; this also rejects a single-cycle glitch.
   for (genvar g = 0; g < 2; g++) begin : g_sync
      logic [`APR_SYNC_DEPTH-1:0] sync_ff;
      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            sync_ff <= '0;
         end else begin
            sync_ff <= {sync_ff[`APR_SYNC_DEPTH-2:0], cmp_raw[g]};
         end
      end
      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            cmp_lvl_ff[g] <= 1'b0;
         end else if (sync_ff[`APR_SYNC_DEPTH-2] == sync_ff[`APR_SYNC_DEPTH-1]) begin
            cmp_lvl_ff[g] <= sync_ff[`APR_SYNC_DEPTH-1];
         end
      end
   end

   // The strobe is made from the same clock by the computer, so it is used
   // directly; a synchroniser here would only skew it against the reference.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         strobe_d_ff <= 1'b0;
      end else begin
         strobe_d_ff <= sample_strobe_i;
      end
   end

   assign strobe_rise = sample_strobe_i && !strobe_d_ff;

   // Length of the present strobe in cycles, saturating at the nominal width.
   // It only feeds the checks, so a strobe of any width is still accepted.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         strobe_run_ff <= '0;
      end else if (!sample_strobe_i) begin
         strobe_run_ff <= '0;
      end else if (strobe_run_ff != RUN_MAX) begin
         strobe_run_ff <= strobe_run_ff + RUN_ONE;
      end
   end

   // Interrogator latch: the zero-phase gate sets it, the pi-phase gate resets
   // it. Both comparators cannot be in their window at once in a working loop;
   // if they are, the latch keeps its value rather than guessing.
   always_comb begin
      nxt_latch = latch_ff;
      if (sample_strobe_i && cmp_lvl_ff[0] && !cmp_lvl_ff[1]) begin
         nxt_latch = APR_POS;
      end else if (sample_strobe_i && cmp_lvl_ff[1] && !cmp_lvl_ff[0]) begin
         nxt_latch = APR_NEG;
      end
   end

   // Latch state.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         latch_ff <= `APR_DIR_RST;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   // One set pulse per strobe, through the gate that the latch enables, so
   // only one of the two can ever fire.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         set_ff <= '0;
      end else begin
         set_ff <= pair_of(nxt_latch, strobe_rise);
      end
   end

   // Data pulse, the differentiated strobe: one cycle per leading edge.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         data_ff <= 1'b0;
      end else begin
         data_ff <= strobe_rise;
      end
   end

   // Torque-direction flip-flop follows only a pulse of the other sign.
   always_comb begin
      nxt_dir = dir_ff;
      if (set_ff.pos) begin
         nxt_dir = APR_POS;
      end else if (set_ff.neg) begin
         nxt_dir = APR_NEG;
      end
   end

   // Direction state.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dir_ff <= `APR_DIR_RST;
      end else begin
         dir_ff <= nxt_dir;
      end
   end

   // Velocity pulses use the direction as updated by the same strobe, so the
   // pulse sign always matches the coil that carries current from then on.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         vel_ff <= '0;
      end else begin
         vel_ff <= pair_of(nxt_dir, data_ff);
      end
   end

   // Forward-backward counter. It wraps at either end after reporting, so a
   // long run in one direction gives one increment per full capacity of counts.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_ff <= CNT_MID;
      end else if (vel_ff.pos) begin
         cnt_ff <= (cnt_ff == CNT_MAX) ? CNT_MIN : cnt_ff + CNT_ONE;
      end else if (vel_ff.neg) begin
         cnt_ff <= (cnt_ff == CNT_MIN) ? CNT_MAX : cnt_ff - CNT_ONE;
      end
   end

   // Increment pulses appear only at the ends of the range; a balanced
   // three-up, three-down pattern from the midpoint never counts past them.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         inc_ff <= '0;
      end else begin
         inc_ff.pos <= vel_ff.pos && (cnt_ff == CNT_MAX);
         inc_ff.neg <= vel_ff.neg && (cnt_ff == CNT_MIN);
      end
   end

   // Outputs; the coil select is a decode of the direction flip-flop only.
   assign torque_set_o = set_ff;
   assign data_pulse_o = data_ff;
   assign coil_o = pair_of(dir_ff, 1'b1);
   assign velocity_o = vel_ff;
   assign increment_o = inc_ff;

   // Checks on the loop logic.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   a_set_exclusive: assert property (!(set_ff.pos && set_ff.neg))
      else $error("Both torque set pulses active.");

   a_set_pos_cause: assert property (strobe_rise && cmp_lvl_ff[0] && !cmp_lvl_ff[1] |=> set_ff.pos)
      else $error("Zero phase strobe gave no positive set.");

   a_set_neg_cause: assert property (strobe_rise && cmp_lvl_ff[1] && !cmp_lvl_ff[0] |=> set_ff.neg)
      else $error("Pi phase strobe gave no negative set.");

   a_latch_quiet: assert property (!sample_strobe_i |=> $stable(latch_ff))
      else $error("Latch moved without a strobe.");

   a_data_edge: assert property (data_ff |-> $past(sample_strobe_i) && !$past(sample_strobe_i, 2))
      else $error("Data pulse not at strobe leading edge.");

   a_data_once: assert property (data_ff |=> !data_ff)
      else $error("Data pulse longer than one cycle.");

   a_dir_follow: assert property (set_ff.pos |=> dir_ff == APR_POS ##1 coil_o.pos)
      else $error("Direction did not take positive state.");

   a_dir_flip: assert property (set_ff.neg |=> dir_ff == APR_NEG && coil_o.neg)
      else $error("Direction did not take negative state.");

   a_dir_hold: assert property (!set_ff.pos && !set_ff.neg |=> $stable(dir_ff))
      else $error("Direction changed without a set pulse.");

   a_coil_onehot: assert property (coil_o.pos != coil_o.neg)
      else $error("Coil select not one-hot.");

   a_vel_sign: assert property (set_ff.pos && data_ff |=> velocity_o.pos && !velocity_o.neg)
      else $error("Positive strobe gave wrong velocity sign.");

   a_vel_needs_data: assert property (velocity_o.pos || velocity_o.neg |-> $past(data_ff))
      else $error("Velocity pulse without a data pulse.");

   a_cnt_up: assert property (vel_ff.pos && cnt_ff != CNT_MAX |=> cnt_ff == $past(cnt_ff) + CNT_ONE)
      else $error("Counter failed to count up.");

   a_cnt_down: assert property (vel_ff.neg && cnt_ff != CNT_MIN |=> cnt_ff == $past(cnt_ff) - CNT_ONE)
      else $error("Counter failed to count down.");

   a_inc_pos: assert property (vel_ff.pos && cnt_ff == CNT_MAX |=> increment_o.pos && cnt_ff == CNT_MIN)
      else $error("Overflow without positive increment and wrap.");

   a_inc_neg: assert property (vel_ff.neg && cnt_ff == CNT_MIN |=> increment_o.neg && cnt_ff == CNT_MAX)
      else $error("Underflow without negative increment and wrap.");

   a_inc_cause: assert property (increment_o.pos || increment_o.neg |-> $past(cnt_ff) == CNT_MAX
      || $past(cnt_ff) == CNT_MIN)
      else $error("Increment away from the range ends.");

   a_reset_state: assert property ($past(reset_i) |-> cnt_ff == CNT_MID && dir_ff == `APR_DIR_RST)
      else $error("Reset state wrong.");

   a_held_strobe: assert property (strobe_run_ff > RUN_ONE |-> !data_ff)
      else $error("Data pulse while the strobe was held high.");

   a_set_needs_rise: assert property (set_ff.pos || set_ff.neg |-> $past(strobe_rise))
      else $error("Torque set pulse without a strobe leading edge.");

   a_latch_both_hold: assert property (sample_strobe_i && cmp_lvl_ff[0] && cmp_lvl_ff[1] |=> $stable(latch_ff))
      else $error("Latch moved with both comparators active.");

   a_coil_dir: assert property (coil_o.pos == (dir_ff == APR_POS))
      else $error("Coil select does not follow the direction.");

   a_vel_exclusive: assert property (!(velocity_o.pos && velocity_o.neg))
      else $error("Both velocity pulses active.");

   a_vel_coil_match: assert property (velocity_o.pos || velocity_o.neg |-> velocity_o == coil_o)
      else $error("Velocity sign differs from the driven coil.");

   a_inc_exclusive: assert property (!(increment_o.pos && increment_o.neg))
      else $error("Both increment pulses active.");

   c_strobe_width: cover property ($rose(sample_strobe_i) ##1 sample_strobe_i [*8]);
   c_dir_reversal: cover property (set_ff.pos ##[1:1000] set_ff.neg);
   c_inc_pos: cover property (increment_o.pos);
   c_inc_neg: cover property (increment_o.neg);
   c_strobe_full: cover property (strobe_run_ff == RUN_MAX);

endmodule : apr_digitizer
`default_nettype wire

// >>> bench/apr_cpu_model.sv
// Behavioural computer model that issues sample strobes and tallies velocity increments.
`timescale 1ns/10ps
`default_nettype none
module apr_cpu_model #(
   parameter int unsigned STB_CYC = 150
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic go_i,
   input wire apr_pkg::apr_pair_s increment_i,
   output logic sample_strobe_o,
   output logic busy_o,
   output logic signed [7:0] net_inc_o
);
   import apr_pkg::*;

   logic [7:0] width_ff;

   // The strobe is timed off the system clock, and a low cycle always follows it so strobes never merge.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sample_strobe_o <= 1'b0;
         width_ff <= 8'h00;
      end else if (width_ff != 8'h00) begin
         width_ff <= width_ff - 8'h01;
         sample_strobe_o <= (width_ff != 8'h01);
      end else if (go_i) begin
         width_ff <= STB_CYC[7:0];
         sample_strobe_o <= 1'b1;
      end
   end

   assign busy_o = (width_ff != 8'h00) || sample_strobe_o;

   // The computer keeps a running sum of the velocity increments it receives.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         net_inc_o <= 8'sh00;
      end else if (increment_i.pos) begin
         net_inc_o <= net_inc_o + 8'sh01;
      end else if (increment_i.neg) begin
         net_inc_o <= net_inc_o - 8'sh01;
      end
   end
endmodule : apr_cpu_model
`default_nettype wire

// >>> bench/apr_digitizer_tb_top.sv
// Self-checking bench for the accelerometer pulse rebalance digitizer.
`timescale 1ns/10ps
`default_nettype none
module apr_digitizer_tb_top;
   import apr_pkg::*;

   typedef struct packed {
      logic z;
      logic p;
      logic [1:0] ts;
      logic [1:0] inc;
   } apr_row_s;

   // Counter starts at 4 of 8: a balanced run, both comparators, none, then overflow and underflow.
   apr_row_s rows [15] = '{6'h28, 6'h28, 6'h28, 6'h14, 6'h14, 6'h14, 6'h34, 6'h04,
                           6'h28, 6'h28, 6'h28, 6'h28, 6'h28, 6'h2A, 6'h15};
   logic clk_i;
   logic reset_i;
   logic zero_phase;
   logic pi_phase;
   logic strobe;
   logic go;
   logic busy;
   logic signed [7:0] net_inc;
   apr_pair_s ts;
   apr_pair_s coil;
   apr_pair_s vel;
   apr_pair_s inc;
   logic dp;
   int error_cnt;
   int checked;

   apr_digitizer #(.CNT_CAP(8)) i_apr_digitizer (.clk_i(clk_i), .reset_i(reset_i), .zero_phase_i(zero_phase),
      .pi_phase_i(pi_phase), .sample_strobe_i(strobe), .torque_set_o(ts), .data_pulse_o(dp), .coil_o(coil),
      .velocity_o(vel), .increment_o(inc));

   apr_cpu_model #(.STB_CYC(150)) i_apr_cpu_model (.clk_i(clk_i), .reset_i(reset_i), .go_i(go),
      .increment_i(inc), .sample_strobe_o(strobe), .busy_o(busy), .net_inc_o(net_inc));

   // Free-running system clock.
   always #10 clk_i = ~clk_i;

   task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One strobe with settled comparator levels; each answer is checked in the cycle it stands.
   task automatic strobe_event(input logic z, input logic p, input logic [1:0] ts_exp, input logic [1:0] inc_exp);
      zero_phase = z;
      pi_phase = p;
      repeat (6) @(posedge clk_i);
      #1 go = 1'b1;
      @(posedge clk_i);
      #1 go = 1'b0;
      @(posedge clk_i);
      #1 chk(ts, ts_exp);
      chk({1'b0, dp}, 2'h1);
      @(posedge clk_i);
      #1 chk(vel, ts_exp);
      chk(coil, ts_exp);
      chk({1'b0, dp}, 2'h0);
      @(posedge clk_i);
      #1 chk(inc, inc_exp);
      chk(ts, 2'h0);
      for (int i = 0; i < 400 && busy; i++) @(posedge clk_i);
      #1 chk({1'b0, busy}, 2'h0);
   endtask : strobe_event

   task automatic complete_run();
      $display("Checks %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // Main sequence: reset, table rows, then a reset in mid-run followed by an overflow from the midpoint.
   initial begin
      clk_i = 1'b0;
      reset_i = 1'b1;
      zero_phase = 1'b0;
      pi_phase = 1'b0;
      go = 1'b0;
      error_cnt = 0;
      checked = 0;
      repeat (20) @(posedge clk_i);
      #1 reset_i = 1'b0;
      chk(coil, 2'h1);
      chk(ts | vel | inc, 2'h0);
      foreach (rows[i]) strobe_event(rows[i].z, rows[i].p, rows[i].ts, rows[i].inc);
      reset_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 reset_i = 1'b0;
      chk(coil, 2'h1);
      repeat (3) strobe_event(1'b1, 1'b0, 2'h2, 2'h0);
      strobe_event(1'b1, 1'b0, 2'h2, 2'h2);
      chk(net_inc[1:0], 2'h1);
      complete_run();
   end

   // Watchdog reckoned at several times the expected run of about 3000 cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      complete_run();
   end
endmodule : apr_digitizer_tb_top
`default_nettype wire
